// File: rtl/csp_pkg.sv
package csp_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSP_STAT_OFS = 8'h04;
  localparam logic [7:0] CSP_IEN_OFS  = 8'h08;
  localparam logic [7:0] CSP_ICLR_OFS = 8'h0c;
  localparam logic [7:0] CSP_TXD_OFS  = 8'h10;
  localparam logic [7:0] CSP_RXD_OFS  = 8'h14;
  localparam logic [7:0] CSP_LINE_OFS = 8'h18;

  // ----------------------------------------------------------------
  // Control register layout and reset value
  // ----------------------------------------------------------------
  localparam int CSP_BAUD_LSB  = 0;
  localparam int CSP_PAR_LSB   = 4;
  localparam int CSP_WID_LSB   = 7;
  localparam int CSP_STOP_BIT  = 9;
  localparam int CSP_EXT_BIT   = 10;
  localparam int CSP_RS232_BIT = 11;
  localparam int CSP_THR_LSB   = 12;
  localparam int CSP_DISC_BIT  = 14;
  localparam int CSP_DCDEN_BIT = 15;
  localparam int CSP_CTSEN_BIT = 16;
  localparam int CSP_CTRL_W    = 17;
  localparam logic [16:0] CSP_CTRL_RST = 17'h1a189;

  // ----------------------------------------------------------------
  // Interrupt status bits and error byte bits
  // ----------------------------------------------------------------
  localparam int CSP_ST_THR  = 0;
  localparam int CSP_ST_DCD  = 1;
  localparam int CSP_ST_CTS  = 2;
  localparam int CSP_ST_QOV  = 3;
  localparam int CSP_ST_TXDN = 4;
  localparam int CSP_NSTAT   = 5;
  localparam int CSP_ERR_INV  = 0;
  localparam int CSP_ERR_BRK  = 3;
  localparam int CSP_ERR_FRM  = 4;
  localparam int CSP_ERR_PAR  = 5;
  localparam int CSP_ERR_HWOV = 6;
  localparam int CSP_ERR_QOV  = 7;

  // ----------------------------------------------------------------
  // Timing and queue sizes
  // ----------------------------------------------------------------
  localparam int CSP_CLK_HZ      = 250_000_000;
  localparam int CSP_OVS         = 16;
  localparam int CSP_TS_UNIT_US  = 10;
  localparam logic [15:0] CSP_TS_MAX = 16'hffff;
  localparam int CSP_FIFO_AW     = 4;
  localparam int CSP_FIFO_W      = 32;

  typedef enum logic [2:0] {
    CSP_PAR_NONE = 3'h0, CSP_PAR_ODD = 3'h1, CSP_PAR_EVEN = 3'h2,
    CSP_PAR_ONE = 3'h3, CSP_PAR_ZERO = 3'h4
  } csp_par_t;

  typedef enum logic [2:0] {
    CSP_S_IDLE = 3'b000, CSP_S_START = 3'b001, CSP_S_DATA = 3'b011,
    CSP_S_PAR = 3'b010, CSP_S_STOP = 3'b110
  } csp_state_t;

  // Line rate in bits per second for each rate code.
  function automatic int cspBaudRate(input logic [3:0] sel);
    case (sel)
      4'h0: return 600;
      4'h1: return 1200;
      4'h2: return 1800;
      4'h3: return 2400;
      4'h4: return 4800;
      4'h5: return 9600;
      4'h6: return 19200;
      4'h7: return 38400;
      4'h8: return 57600;
      default: return 115200;
    endcase
  endfunction

  // Receive interrupt threshold in bytes for each threshold code.
  function automatic logic [4:0] cspThreshold(input logic [1:0] sel);
    case (sel)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h0e;
    endcase
  endfunction

endpackage

// File: rtl/csp_tick_gen.sv
`timescale 1ns/1ps
module csp_tick_gen
  import csp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Rate
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count;
  wire         wrap = (count >= divisor - 16'h0001);

  // Free running divider; a rate change takes effect within one period.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) count <= 16'h0000;
    else         count <= wrap ? 16'h0000 : count + 16'h0001;
  end

  assign tick = wrap;
endmodule

// File: rtl/csp_fifo_mem.sv
`timescale 1ns/1ps
module csp_fifo_mem
  import csp_pkg::*;
(
  // Clock
  input  wire logic                   sys_clk,
  // Write side
  input  wire logic                   wrEn,
  input  wire logic [CSP_FIFO_AW-1:0] wrAddr,
  input  wire logic [CSP_FIFO_W-1:0]  wrData,
  // Read side, data one cycle after the address
  input  wire logic [CSP_FIFO_AW-1:0] rdAddr,
  output logic      [CSP_FIFO_W-1:0]  rdData
);
  logic [CSP_FIFO_W-1:0] mem [2**CSP_FIFO_AW];

  // Registered read keeps the array mappable onto block memory.
  always_ff @(posedge sys_clk)
  begin
    if (wrEn) mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule

// File: rtl/csp_serial_port.sv
`timescale 1ns/1ps
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int CLK_HZ = CSP_CLK_HZ
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxdPin,
  input  wire logic        dcdPin,
  input  wire logic        ctsPin,
  output logic             txdPin,
  output logic             rs485De,
  // Events and interrupt
  output logic             carrierEvent,
  output logic             ctsEvent,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int TS_CYC = CLK_HZ / 1_000_000 * CSP_TS_UNIT_US;

  // ----------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------
  logic [CSP_CTRL_W-1:0] ctrl;
  logic [CSP_NSTAT-1:0]  stat;
  logic [CSP_NSTAT-1:0]  ien;
  logic                  waitDone;
  logic [4:0]            count;
  logic [4:0]            cntSeen;
  logic [CSP_FIFO_AW-1:0] wrPtr;
  logic [CSP_FIFO_AW-1:0] rdPtr;
  logic [CSP_FIFO_W-1:0]  rdWord;
  csp_state_t            txState;
  logic                  rxSync;
  logic                  dcdSync;
  logic                  ctsSync;

  wire        access   = psel & penable & waitDone;
  wire        wrAcc    = access & pwrite;
  wire        rdAcc    = access & ~pwrite;
  wire        selCtrl  = (paddr == CSP_CTRL_OFS);
  wire        selStat  = (paddr == CSP_STAT_OFS);
  wire        selIen   = (paddr == CSP_IEN_OFS);
  wire        selIclr  = (paddr == CSP_ICLR_OFS);
  wire        selTxd   = (paddr == CSP_TXD_OFS);
  wire        selRxd   = (paddr == CSP_RXD_OFS);
  wire        selLine  = (paddr == CSP_LINE_OFS);
  wire        mapped   = selCtrl | selStat | selIen | selIclr | selTxd | selRxd | selLine;
  wire        txBusy   = (txState != CSP_S_IDLE);
  wire        txStart  = wrAcc & selTxd & ~txBusy;
  wire        rxAvail  = (cntSeen != 5'h00) & (count != 5'h00);
  wire        pop      = rdAcc & selRxd & rxAvail;
  wire        extMode  = ctrl[CSP_EXT_BIT];
  wire        rs232    = ctrl[CSP_RS232_BIT];
  wire [1:0]  widSel   = ctrl[CSP_WID_LSB +: 2];
  wire [2:0]  lastBit  = {1'b1, widSel};                          // Width minus one.
  wire [2:0]  parSel   = ctrl[CSP_PAR_LSB +: 3];
  wire        parOn    = (parSel != CSP_PAR_NONE);
  wire [5:0]  stopTk   = ~ctrl[CSP_STOP_BIT] ? 6'd16 :
                         (widSel == 2'h0) ? 6'd24 : 6'd32;
  wire [15:0] divisor  = 16'(CLK_HZ / (CSP_OVS * cspBaudRate(ctrl[CSP_BAUD_LSB +: 4])));
  wire [31:0] rxdWord  = extMode ? rdWord : {24'h000000, rdWord[7:0]};

  // Parity of the character bits that are in use, in the selected mode.
  function automatic logic parityOf(input logic [7:0] d, input logic [2:0] lb,
                                    input logic [2:0] mode);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 8; i++)
      if (3'(i) <= lb) x = x ^ d[i];
    case (mode)
      CSP_PAR_ODD:  return ~x;
      CSP_PAR_EVEN: return x;
      CSP_PAR_ONE:  return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction

  // One wait state on every access; the memory read data settles in it.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) waitDone <= 1'b0;
    else         waitDone <= psel & penable & ~waitDone;
  end

  assign pready  = psel & penable & waitDone;
  assign pslverr = access & (~mapped | (pwrite & selTxd & txBusy) |
                   (pwrite & (selStat | selRxd | selLine)));

  // Read data is captured in the wait state, so it comes from a flop.
  wire [31:0] next_prdata =
    selCtrl ? 32'(ctrl) :
    selStat ? 32'(stat) :
    selIen  ? 32'(ien) :
    (selRxd & rxAvail) ? rxdWord :
    selLine ? {22'h000000, count, txBusy, ctsSync, dcdSync, rxSync, rxAvail} :
    32'h00000000;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)                               prdata <= 32'h00000000;
    else if (psel & penable & ~waitDone & ~pwrite) prdata <= next_prdata;
  end

  // Configuration; a control write is a reconfiguration that restarts silence timing.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl <= CSP_CTRL_RST;
      ien  <= '0;
    end
    else
    begin
      if (wrAcc & selCtrl) ctrl <= pwdata[CSP_CTRL_W-1:0];
      if (wrAcc & selIen)  ien  <= pwdata[CSP_NSTAT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and modem line events
  // ----------------------------------------------------------------
  logic [1:0] rxMeta;
  logic [1:0] dcdMeta;
  logic [1:0] ctsMeta;
  logic       dcdLast;
  logic       ctsLast;

  // Two flops per pin; a third stage on DCD and CTS holds the previous level for edges.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rxMeta <= 2'b11;
      dcdMeta <= 2'b00;
      ctsMeta <= 2'b00;
      dcdLast <= 1'b0;
      ctsLast <= 1'b0;
    end
    else
    begin
      rxMeta  <= {rxMeta[0], rxdPin};
      dcdMeta <= {dcdMeta[0], dcdPin};
      ctsMeta <= {ctsMeta[0], ctsPin};
      dcdLast <= dcdMeta[1];
      ctsLast <= ctsMeta[1];
    end
  end

  assign rxSync  = rxMeta[1];
  assign dcdSync = dcdMeta[1];
  assign ctsSync = ctsMeta[1];
  assign carrierEvent = ctrl[CSP_DCDEN_BIT] & (dcdSync ^ dcdLast);
  assign ctsEvent     = ctrl[CSP_CTSEN_BIT] & (ctsSync ^ ctsLast);

  // ----------------------------------------------------------------
  // Oversampling tick and silence timer
  // ----------------------------------------------------------------
  logic        tick;
  logic [11:0] usCnt;
  logic [15:0] silence;
  logic        rxDone;
  logic        txDone;

  csp_tick_gen u_tick (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .divisor (divisor),
    .tick    (tick)
  );

  wire tsTick    = (usCnt == 12'(TS_CYC - 1));
  wire tsRestart = rxDone | txDone | (wrAcc & selCtrl);

  // Silence counter saturates rather than wrapping, so long gaps stay long.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst | tsRestart)
    begin
      usCnt   <= 12'h000;
      silence <= 16'h0000;
    end
    else
    begin
      usCnt <= tsTick ? 12'h000 : usCnt + 12'h001;
      if (tsTick & (silence != CSP_TS_MAX)) silence <= silence + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  csp_state_t  rxState;
  logic [3:0]  rxTk;
  logic [2:0]  rxIdx;
  logic [7:0]  rxData;
  logic        rxPar;
  logic        rxZero;
  logic        rxStop;
  logic [15:0] tsCap;
  logic        hwOvPend;

  wire rxMid = tick & (rxTk == 4'hf);

  // Start is confirmed at mid bit; data, parity and stop sampled mid bit.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst | (wrAcc & selCtrl))
    begin
      rxState <= CSP_S_IDLE;
      rxTk <= 4'h0;
      rxIdx <= 3'h0;
      rxData <= 8'h00;
      rxPar <= 1'b0;
      rxZero <= 1'b1;
      rxStop <= 1'b1;
      tsCap <= 16'h0000;
    end
    else
    begin
      if (tick) rxTk <= rxTk + 4'h1;
      unique case (rxState)
        CSP_S_IDLE:
          if (~rxSync)
          begin
            rxState <= CSP_S_START;
            rxTk <= 4'h0;
          end
        CSP_S_START:
          if (tick & (rxTk == 4'h7))
          begin
            rxState <= rxSync ? CSP_S_IDLE : CSP_S_DATA;
            rxTk <= 4'h0;
            rxIdx <= 3'h0;
            rxData <= 8'h00;
            rxZero <= 1'b1;
            tsCap <= silence;
          end
        CSP_S_DATA:
          if (rxMid)
          begin
            rxData[rxIdx] <= rxSync;
            rxZero <= rxZero & ~rxSync;
            rxIdx <= rxIdx + 3'h1;
            if (rxIdx == lastBit) rxState <= parOn ? CSP_S_PAR : CSP_S_STOP;
          end
        CSP_S_PAR:
          if (rxMid)
          begin
            rxPar <= rxSync;
            rxZero <= rxZero & ~rxSync;
            rxState <= CSP_S_STOP;
          end
        CSP_S_STOP:
          if (rxMid)
          begin
            rxStop <= rxSync;
            rxState <= CSP_S_IDLE;
          end
        default: rxState <= CSP_S_IDLE;
      endcase
    end
  end

  // Pulse marking a finished character; the flags it uses are now stable.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) rxDone <= 1'b0;
    else         rxDone <= rxMid & (rxState == CSP_S_STOP) & ~(wrAcc & selCtrl);
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  wire       full    = (count == 5'h10);
  wire       drop    = ctrl[CSP_DISC_BIT] & rs232 & txBusy;
  wire       push    = rxDone & ~drop;
  wire       ovWrite = push & full & ~pop;                        // Oldest entry is lost.
  wire [4:0] thr     = cspThreshold(ctrl[CSP_THR_LSB +: 2]);
  wire       brkErr  = rxZero & ~rxStop;
  wire       frmErr  = ~rxStop;
  wire       parErr  = parOn & (rxPar != parityOf(rxData, lastBit, parSel));
  wire [4:0] next_count = count + 5'(push & ~ovWrite) - 5'(pop);

  logic [7:0] errByte;
  always_comb
  begin
    errByte = 8'h00;
    errByte[CSP_ERR_BRK]  = brkErr;
    errByte[CSP_ERR_FRM]  = frmErr;
    errByte[CSP_ERR_PAR]  = parErr;
    errByte[CSP_ERR_HWOV] = hwOvPend;
    errByte[CSP_ERR_QOV]  = full & ~pop;
    errByte[CSP_ERR_INV]  = brkErr | frmErr | parErr;
  end

  csp_fifo_mem u_mem (
    .sys_clk (sys_clk),
    .wrEn    (push),
    .wrAddr  (wrPtr),
    .wrData  ({tsCap, errByte, rxData}),
    .rdAddr  (rdPtr),
    .rdData  (rdWord)
  );

  // A full queue keeps the newest character and drops the oldest unread one.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= 5'h00;
      cntSeen <= 5'h00;
      hwOvPend <= 1'b0;
    end
    else
    begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop | ovWrite) rdPtr <= rdPtr + 1'b1;
      count <= next_count;
      cntSeen <= count;
      if (ovWrite) hwOvPend <= 1'b1;
      else if (push) hwOvPend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [7:0] txData;
  logic [5:0] txTk;
  logic [2:0] txIdx;
  logic       txPar;

  wire txBitEnd = tick & (txTk == 6'd15);

  // Bits last sixteen ticks; only the stop length varies.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txState <= CSP_S_IDLE;
      txTk <= 6'h00;
      txIdx <= 3'h0;
      txData <= 8'h00;
      txPar <= 1'b0;
      txDone <= 1'b0;
    end
    else
    begin
      txDone <= 1'b0;
      if (tick) txTk <= txTk + 6'h01;
      unique case (txState)
        CSP_S_IDLE:
          if (txStart)
          begin
            txData <= pwdata[7:0];
            txPar <= parityOf(pwdata[7:0], lastBit, parSel);
            txTk <= 6'h00;
            txIdx <= 3'h0;
            txState <= CSP_S_START;
          end
        CSP_S_START:
          if (txBitEnd)
          begin
            txTk <= 6'h00;
            txState <= CSP_S_DATA;
          end
        CSP_S_DATA:
          if (txBitEnd)
          begin
            txTk <= 6'h00;
            txIdx <= txIdx + 3'h1;
            if (txIdx == lastBit) txState <= parOn ? CSP_S_PAR : CSP_S_STOP;
          end
        CSP_S_PAR:
          if (txBitEnd)
          begin
            txTk <= 6'h00;
            txState <= CSP_S_STOP;
          end
        CSP_S_STOP:
          if (tick & (txTk == stopTk - 6'h01))
          begin
            txState <= CSP_S_IDLE;
            txDone <= 1'b1;
          end
        default: txState <= CSP_S_IDLE;
      endcase
    end
  end

  // Line level from the current transmit state; idle line is high.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txdPin <= 1'b1;
      rs485De <= 1'b0;
    end
    else
    begin
      txdPin <= (txState == CSP_S_START) ? 1'b0 :
                (txState == CSP_S_DATA)  ? txData[txIdx] :
                (txState == CSP_S_PAR)   ? txPar : 1'b1;
      rs485De <= txBusy & ~rs232;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [CSP_NSTAT-1:0] evt;
  always_comb
  begin
    evt[CSP_ST_THR]  = push & (next_count == thr);
    evt[CSP_ST_DCD]  = carrierEvent;
    evt[CSP_ST_CTS]  = ctsEvent;
    evt[CSP_ST_QOV]  = ovWrite;
    evt[CSP_ST_TXDN] = txDone;
  end

  wire [CSP_NSTAT-1:0] clr = (wrAcc & selIclr) ? pwdata[CSP_NSTAT-1:0] : '0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) stat <= '0;
    else         stat <= (stat & ~clr) | evt;
  end

  assign irq = |(stat & ien);
endmodule

// File: verif/csp_serial_port_checker.sv
`timescale 1ns/1ps
module csp_serial_port_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Line and events
  input wire logic dcdPin,
  input wire logic ctsPin,
  input wire logic txdPin,
  input wire logic carrierEvent,
  input wire logic ctsEvent,
  input wire logic irq
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ------------
  // Bus timing
  // ------------
  chk_ready_in_access:
    assert property (pready |-> psel && penable) else $error("pready outside access");
  chk_ready_latency:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("pready late");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");

  // ------------
  // Events, interrupt and line
  // ------------
  // Synchronised modem lines show a change within a few cycles.
  chk_dcd_pulse:
    assert property (carrierEvent |=> !carrierEvent) else $error("dcd event too long");
  chk_cts_pulse:
    assert property (ctsEvent |=> !ctsEvent) else $error("cts event too long");
  chk_dcd_quiet:
    assert property ($stable(dcdPin) [*5] |-> !carrierEvent) else $error("dcd event, no change");
  chk_cts_quiet:
    assert property ($stable(ctsPin) [*5] |-> !ctsEvent) else $error("cts event, no change");
  chk_irq_sticky:
    assert property (irq && !(psel && pwrite) |=> irq) else $error("irq dropped by itself");
  chk_txd_idle:
    assert property ($fell(sys_rst) |-> txdPin) else $error("txd not idle after reset");
  chk_start_width:
    assert property ($fell(txdPin) |-> !txdPin [*8]) else $error("start bit too short");
endmodule

bind csp_serial_port csp_serial_port_checker u_csp_serial_port_checker (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .dcdPin(dcdPin),
  .ctsPin(ctsPin), .txdPin(txdPin), .carrierEvent(carrierEvent),
  .ctsEvent(ctsEvent), .irq(irq)
);

// File: verif/csp_remote_station.sv
`timescale 1ns/1ps
module csp_remote_station
#(
  parameter int BIT_CYC = 128
)
(
  // Clock
  input  wire logic sys_clk,
  // Serial line
  input  wire logic txdPin,
  output logic      rxdPin
);
  // The line rests at mark level between frames.
  initial rxdPin = 1'b1;

  // Start bit, then n bits LSB first; the caller supplies parity and stop.
  task automatic send(input logic [11:0] bits, input int n);
    rxdPin <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      rxdPin <= bits[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rxdPin <= 1'b1;
  endtask

  // Samples n bits after the start bit, each at mid-bit.
  task automatic recv(input int n, output logic [11:0] bits);
    bits = '0;
    @(negedge txdPin);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_CYC) @(posedge sys_clk);
      bits[i] = txdPin;
    end
  endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb
  import csp_pkg::*;
;
  // One bit is 128 cycles at rate code 9 on the slow clock.
  localparam int BIT = 128;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxdPin;
  logic        dcdPin;
  logic        ctsPin;
  logic        txdPin;
  logic        rs485De;
  logic        carrierEvent;
  logic        ctsEvent;
  logic        irq;
  int          num_errors;
  int          compares;

  csp_serial_port #(.CLK_HZ(16_000_000)) u_csp_serial_port (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxdPin(rxdPin), .dcdPin(dcdPin), .ctsPin(ctsPin), .txdPin(txdPin), .rs485De(rs485De),
    .carrierEvent(carrierEvent), .ctsEvent(ctsEvent), .irq(irq));
  csp_remote_station #(.BIT_CYC(BIT)) u_csp_remote_station (
    .sys_clk(sys_clk), .txdPin(txdPin), .rxdPin(rxdPin));

  // Clock generator.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // APB master: holds the request until pready, then lets outputs settle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  // Control word: rate 115200, both modem events on, rest as given.
  function automatic logic [31:0] ctrl(input int par, input int w, input int st, input int ext,
                                       input int thr, input int rs, input int disc);
    return 32'h18009 | 32'(par << CSP_PAR_LSB) | 32'((w - 5) << CSP_WID_LSB)
      | 32'(st << CSP_STOP_BIT) | 32'(ext << CSP_EXT_BIT) | 32'(rs << CSP_RS232_BIT)
      | 32'(thr << CSP_THR_LSB) | 32'(disc << CSP_DISC_BIT);
  endfunction

  task automatic test_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, CSP_CTRL_OFS, '0, r, e);
    chk("ctrl reset", 32'h1a189, r);
    apb(1'b0, CSP_IEN_OFS, '0, r, e);
    chk("ien reset", 32'h0, r);
    apb(1'b1, CSP_STAT_OFS, 32'h1f, r, e);
    chk("stat write err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h1c, '0, r, e);
    chk("unmapped read", 32'h1, {r[30:0], e});
    $display("test_reset done");
  endtask

  // Every parity mode and width; long stop checked where it is two bits.
  task automatic test_tx_formats();
    int          wid [6] = '{8, 5, 6, 7, 8, 6};
    int          par [6] = '{0, 1, 2, 3, 4, 2};
    int          stp [6] = '{0, 1, 0, 0, 0, 1};
    logic [31:0] r;
    logic        e;
    logic [11:0] got;
    logic [11:0] exp;
    logic [7:0]  d;
    logic        p;
    int          n;
    for (int i = 0; i < 6; i++)
    begin
      d = 8'hb5 ^ 8'(i * 37);
      p = 1'b0;
      n = wid[i] + (par[i] != 0) + 1 + (stp[i] != 0 && wid[i] != 5);
      exp = '0;
      for (int b = 0; b < n; b++) exp[b] = 1'b1;
      for (int b = 0; b < wid[i]; b++) exp[b] = d[b];
      for (int b = 0; b < wid[i]; b++) p = p ^ d[b];
      if (par[i] != 0) exp[wid[i]] = par[i] == 1 ? ~p : par[i] == 2 ? p : par[i] == 3;
      apb(1'b1, CSP_CTRL_OFS, ctrl(par[i], wid[i], stp[i], 0, 2, 0, 0), r, e);
      fork
        u_csp_remote_station.recv(n, got);
        apb(1'b1, CSP_TXD_OFS, {24'h0, d}, r, e);
      join
      chk("tx frame", {20'h0, exp}, {20'h0, got});
      repeat (2 * BIT) @(posedge sys_clk);
    end
    $display("test_tx_formats done");
  endtask

  task automatic test_rx_threshold();
    logic [31:0] r;
    logic        e;
    apb(1'b1, CSP_CTRL_OFS, ctrl(0, 8, 0, 0, 1, 0, 0), r, e);
    apb(1'b1, CSP_ICLR_OFS, 32'h1f, r, e);
    apb(1'b1, CSP_IEN_OFS, 32'h1, r, e);
    for (int i = 0; i < 4; i++)
    begin
      chk("irq below threshold", 32'h0, {31'h0, irq});
      u_csp_remote_station.send({4'hf, 8'h30 + 8'(i)}, 9);
      repeat (BIT) @(posedge sys_clk);
    end
    chk("irq at threshold", 32'h1, {31'h0, irq});
    apb(1'b1, CSP_IEN_OFS, 32'h0, r, e);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, CSP_IEN_OFS, 32'h1, r, e);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, CSP_RXD_OFS, '0, r, e);
      chk("rx data", 32'h30 + 32'(i), r);
    end
    apb(1'b0, CSP_RXD_OFS, '0, r, e);
    chk("rx empty", 32'h0, r);
    apb(1'b1, CSP_ICLR_OFS, 32'h1, r, e);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test_rx_threshold done");
  endtask

  // A framing fault after 1600 cycles, ten silence units of 160 cycles.
  task automatic test_extended();
    logic [31:0] r;
    logic        e;
    apb(1'b1, CSP_CTRL_OFS, ctrl(0, 8, 0, 1, 2, 0, 0), r, e);
    repeat (1600) @(posedge sys_clk);
    u_csp_remote_station.send({4'he, 8'h5a}, 9);
    repeat (BIT) @(posedge sys_clk);
    apb(1'b0, CSP_RXD_OFS, '0, r, e);
    chk("ext data", 32'h5a, {24'h0, r[7:0]});
    chk("ext error", 32'h11, {24'h0, r[15:8]});
    chk("ext silence", 32'd10, {16'h0, r[31:16]});
    $display("test_extended done");
  endtask

  task automatic test_events();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 2; i++)
    begin
      for (int en = 1; en >= 0; en--)
      begin
        apb(1'b1, CSP_CTRL_OFS, ctrl(0, 8, 0, 0, 2, 0, 0) & ~(32'(1 - en) << (15 + i)), r, e);
        apb(1'b1, CSP_ICLR_OFS, 32'h1f, r, e);
        if (i == 0) dcdPin <= 1'(en); else ctsPin <= 1'(en);
        repeat (6) @(posedge sys_clk);
        apb(1'b0, CSP_STAT_OFS, '0, r, e);
        chk("modem event", 32'(en), {31'h0, r[CSP_ST_DCD + i]});
      end
    end
    $display("test_events done");
  endtask

  // A byte arriving during transmit is dropped in RS-232C mode only.
  task automatic test_discard();
    logic [31:0] r;
    logic        e;
    logic [11:0] got;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CSP_CTRL_OFS, ctrl(0, 8, 0, 0, 2, 1 - i, 1), r, e);
      fork
        u_csp_remote_station.recv(9, got);
        begin
          apb(1'b1, CSP_TXD_OFS, 32'h3c, r, e);
          repeat (32) @(posedge sys_clk);
          chk("rs485De", 32'(i), {31'h0, rs485De});
          u_csp_remote_station.send({4'hf, 8'hc3}, 9);
        end
      join
      repeat (BIT) @(posedge sys_clk);
      apb(1'b0, CSP_LINE_OFS, '0, r, e);
      chk("rx kept", 32'(i), {31'h0, r[0]});
      apb(1'b0, CSP_RXD_OFS, '0, r, e);
    end
    $display("test_discard done");
  endtask

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog, about three times what the tests need.
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dcdPin = 1'b0;
    ctsPin = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_tx_formats();
    test_rx_threshold();
    test_extended();
    test_events();
    test_discard();
    complete_run();
  end
endmodule
